/* logic/calib_cfg.svh */
`ifndef CALIB_CFG_SVH
`define CALIB_CFG_SVH

// ----------------------------------------
// register indices, byte address is 4x
// ----------------------------------------
`define IDX_CTRL      8'h61
`define IDX_CFG_A     8'h62
`define IDX_CFG_B     8'h64
`define IDX_AVG       8'h68
`define IDX_STATUS    8'h6a
`define IDX_INT_STAT  8'h70
`define IDX_INT_MASK  8'h71
`define IDX_BG_CTRL   8'h72

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_CTRL      8'h01
`define RST_CFG_A     8'h01
`define RST_CFG_B     8'h02
`define RST_AVG       8'h61

// ----------------------------------------
// field positions
// ----------------------------------------
`define BIT_RUN       0
`define BIT_FG        0
`define BIT_BG        1
`define BIT_FG_OS     2
`define BIT_BG_OS     3
`define LSB_CORE      0
`define LSB_LIN_AVG   0
`define LSB_OFFSET_AVERAGING_DEPTH    4
`define LSB_STAT_CODE 2
`define BIT_STOPPED   1
`define BIT_FOREGROUND_COMPLETE_FLAG   0
`define BIT_EV_FG     0
`define BIT_EV_STOP   1
`define BIT_STOP_REQ  0

// ----------------------------------------
// excluded core codes
// ----------------------------------------
`define CORE_CODE_0   2'h0
`define CORE_CODE_1   2'h1
`define CORE_CODE_2   2'h2

`endif

/* logic/calib_pkg.sv */
package calib_pkg;

  // ----------------------------------------
  // sequencer states, one-hot
  // ----------------------------------------
  typedef enum logic [6:0] {
    ST_HOLD    = 7'h01,
    ST_CLEAR   = 7'h02,
    ST_FG_LIN  = 7'h04,
    ST_FG_OS   = 7'h08,
    ST_BG_RUN  = 7'h10,
    ST_BG_STOP = 7'h20,
    ST_DONE    = 7'h40
  } cal_state_t;

  // ----------------------------------------
  // status codes shown to software
  // ----------------------------------------
  typedef enum logic [2:0] {
    CODE_HOLD    = 3'h0,
    CODE_CLEAR   = 3'h1,
    CODE_FG_LIN  = 3'h2,
    CODE_FG_OS   = 3'h3,
    CODE_BG_RUN  = 3'h4,
    CODE_BG_STOP = 3'h5,
    CODE_DONE    = 3'h6
  } cal_code_t;

endpackage

/* logic/converter_calibration_control.sv */
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/100ps
`include "calib_cfg.svh"
// Functional notes
// - run bit high calibrates, low holds reset
// - run bit low also resets clock dividers
// - foreground select: clear values, maybe calibrate
// - config bit 1 enables background calibration
// - config bit 2 foreground offset, needs foreground
// - config bit 3 background offset, needs background
// - two-bit field picks excluded core
// - bits 6:4 offset averaging depth, reset 6
// - bits 2:0 linearity averaging depth, reset 1
// - read-only status with three-bit code
// - stop flag set when background halted
// - stop flag clears when calibration resumes
// - no background: stop flag at foreground end
// - bit 0 high once foreground done/skipped
module converter_calibration_control #(
  parameter int ADDR_W   = 12,  // byte address width
  parameter int BASE_CYC = 16   // cycles of one averaging unit
) (
  input  wire logic              clk_i,
  input  wire logic              arst_n_i,
  input  wire logic              ce_i,
  input  wire logic              hsel_i,
  input  wire logic [ADDR_W-1:0] haddr_i,
  input  wire logic [1:0]        htrans_i,
  input  wire logic              hwrite_i,
  input  wire logic [2:0]        hsize_i,
  input  wire logic [31:0]       hwdata_i,
  input  wire logic              hready_i,
  output logic      [31:0]       hrdata_o,
  output logic                   hreadyout_o,
  output logic                   hresp_o,
  input  wire logic              link_output_enable_i,
  output logic                   cal_reset_o,
  output logic                   divider_reset_o,
  output logic                   cal_values_clear_o,
  output logic                   fg_running_o,
  output logic                   fg_offset_running_o,
  output logic                   bg_running_o,
  output logic                   bg_offset_running_o,
  output logic      [2:0]        offset_averaging_depth_o,
  output logic      [2:0]        linearity_averaging_depth_o,
  output logic      [2:0]        core_disable_o,
  output logic                   core_standin_o,
  output logic                   irq_o
);
  import calib_pkg::*;

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  localparam int IDX_W = ADDR_W - 2;
  localparam int CNT_W = $clog2(BASE_CYC + 1) + 8;

  generate
    if (ADDR_W < 10 || ADDR_W > 32) begin : g_bad_addr
      $error("address width must hold all registers");
    end
    if (BASE_CYC < 1 || BASE_CYC > 65536) begin : g_bad_base
      $error("averaging unit out of range");
    end
  endgenerate

  // ----------------------------------------
  // register state
  // ----------------------------------------
  logic             run;          // calibration run bit
  logic [3:0]       cfg_a;        // select bits
  logic [1:0]       core_sel;     // excluded core code
  logic [2:0]       offset_averaging_depth;       // offset averaging
  logic [2:0]       lin_avg;      // linearity averaging
  logic [1:0]       int_stat;     // sticky events
  logic [1:0]       int_mask;     // event enables
  logic             stop_req;     // background halt request
  logic             foreground_complete_flag;      // foreground finished
  logic             cal_stopped;  // background halted

  // ----------------------------------------
  // bus phase state
  // ----------------------------------------
  logic             ph_we;        // write data phase pending
  logic [IDX_W-1:0] ph_idx;       // word index of that write
  logic             bus_take;     // address phase accepted

  // ----------------------------------------
  // sequencer state
  // ----------------------------------------
  cal_state_t       state;
  cal_state_t       next_state;
  logic [CNT_W-1:0] cnt;          // cycles left in a phase
  logic [CNT_W-1:0] next_cnt;
  logic             ev_fg;        // foreground end this cycle
  logic             ev_stop;      // stop flag rising this cycle

  // ----------------------------------------
  // helper functions
  // ----------------------------------------
  // word index match, used by every write decode
  function automatic logic hit(input logic [IDX_W-1:0] idx,
                               input logic [7:0]       off);
    hit = (idx == IDX_W'(off));
  endfunction

  // phase length grows by power of two with depth
  function automatic logic [CNT_W-1:0] span(input logic [2:0] d);
    span = CNT_W'(BASE_CYC) << d;
  endfunction

  // status code for each state
  function automatic cal_code_t code_of(input cal_state_t s);
    case (s)
      ST_CLEAR:   code_of = CODE_CLEAR;
      ST_FG_LIN:  code_of = CODE_FG_LIN;
      ST_FG_OS:   code_of = CODE_FG_OS;
      ST_BG_RUN:  code_of = CODE_BG_RUN;
      ST_BG_STOP: code_of = CODE_BG_STOP;
      ST_DONE:    code_of = CODE_DONE;
      default:    code_of = CODE_HOLD;
    endcase
  endfunction

  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  // zero wait state, always okay
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign bus_take    = ce_i & hsel_i & hready_i & htrans_i[1];

  // capture write address phase
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ph_we  <= 1'b0;
      ph_idx <= '0;
    end else if (ce_i) begin
      ph_we  <= bus_take & hwrite_i;
      ph_idx <= haddr_i[ADDR_W-1:2];
    end
  end

  // read data launched in address phase, held after
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hrdata_o <= 32'h0;
    end else if (bus_take && !hwrite_i) begin
      hrdata_o <= {24'h0, rd_byte(haddr_i[ADDR_W-1:2])};
    end
  end

  // read mux, unmapped words read zero
  function automatic logic [7:0] rd_byte(input logic [IDX_W-1:0] i);
    rd_byte = 8'h0;
    if (hit(i, `IDX_CTRL)) begin
      rd_byte[`BIT_RUN] = run;
    end else if (hit(i, `IDX_CFG_A)) begin
      rd_byte[3:0] = cfg_a;
    end else if (hit(i, `IDX_CFG_B)) begin
      rd_byte[1:0] = core_sel;
    end else if (hit(i, `IDX_AVG)) begin
      rd_byte[6:4] = offset_averaging_depth;
      rd_byte[2:0] = lin_avg;
    end else if (hit(i, `IDX_STATUS)) begin
      rd_byte[4:2]          = code_of(state);
      rd_byte[`BIT_STOPPED] = cal_stopped;
      rd_byte[`BIT_FOREGROUND_COMPLETE_FLAG] = foreground_complete_flag;
    end else if (hit(i, `IDX_INT_STAT)) begin
      rd_byte[1:0] = int_stat;
    end else if (hit(i, `IDX_INT_MASK)) begin
      rd_byte[1:0] = int_mask;
    end else if (hit(i, `IDX_BG_CTRL)) begin
      rd_byte[`BIT_STOP_REQ] = stop_req;
    end
  endfunction

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  // writes land in the data phase; status ignores them
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      run      <= 1'(`RST_CTRL);
      cfg_a    <= 4'(`RST_CFG_A);
      core_sel <= 2'(`RST_CFG_B);
      offset_averaging_depth   <= 3'(`RST_AVG >> `LSB_OFFSET_AVERAGING_DEPTH);
      lin_avg  <= 3'(`RST_AVG);
      int_mask <= 2'h0;
      stop_req <= 1'b0;
    end else if (ce_i && ph_we) begin
      if (hit(ph_idx, `IDX_CTRL)) begin
        run <= hwdata_i[`BIT_RUN];
      end else if (hit(ph_idx, `IDX_CFG_A)) begin
        cfg_a <= hwdata_i[3:0];
      end else if (hit(ph_idx, `IDX_CFG_B)) begin
        core_sel <= hwdata_i[1:0];
      end else if (hit(ph_idx, `IDX_AVG)) begin
        offset_averaging_depth  <= hwdata_i[6:4];
        lin_avg <= hwdata_i[2:0];
      end else if (hit(ph_idx, `IDX_INT_MASK)) begin
        int_mask <= hwdata_i[1:0];
      end else if (hit(ph_idx, `IDX_BG_CTRL)) begin
        stop_req <= hwdata_i[`BIT_STOP_REQ];
      end
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  // next state; run low overrides everything
  always_comb begin
    next_state = state;
    next_cnt   = (cnt != '0) ? cnt - CNT_W'(1) : cnt;
    ev_fg      = 1'b0;
    ev_stop    = 1'b0;
    case (state)
      ST_HOLD: begin
        if (run) begin
          next_state = ST_CLEAR;
        end
      end
      ST_CLEAR: begin
        // values cleared, then fg or skip
        if (cfg_a[`BIT_FG]) begin
          next_state = ST_FG_LIN;
          next_cnt   = span(lin_avg);
        end else begin
          ev_fg = 1'b1;
        end
      end
      ST_FG_LIN: begin
        if (cnt == '0) begin
          if (cfg_a[`BIT_FG_OS]) begin
            next_state = ST_FG_OS;
            next_cnt   = span(offset_averaging_depth);
          end else begin
            ev_fg = 1'b1;
          end
        end
      end
      ST_FG_OS: begin
        if (cnt == '0) begin
          ev_fg = 1'b1;
        end
      end
      ST_BG_RUN: begin
        if (!cfg_a[`BIT_BG]) begin
          next_state = ST_DONE;
          ev_stop    = 1'b1;
        end else if (cnt == '0) begin
          // halt at end of current phase
          if (stop_req) begin
            next_state = ST_BG_STOP;
            ev_stop    = 1'b1;
          end else begin
            next_cnt = span(lin_avg);
          end
        end
      end
      ST_BG_STOP: begin
        if (!stop_req) begin
          next_state = ST_BG_RUN;
          next_cnt   = span(lin_avg);
        end
      end
      default: begin
        next_state = ST_DONE;
      end
    endcase
    // foreground ends: go background or rest
    if (ev_fg) begin
      if (cfg_a[`BIT_BG]) begin
        next_state = ST_BG_RUN;
        next_cnt   = span(lin_avg);
      end else begin
        next_state = ST_DONE;
        ev_stop    = 1'b1;
      end
    end
    // run low holds calibration in reset
    if (!run) begin
      next_state = ST_HOLD;
      next_cnt   = '0;
      ev_fg      = 1'b0;
      ev_stop    = 1'b0;
    end
  end

  // state and phase counter
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= ST_HOLD;
      cnt   <= '0;
    end else if (ce_i) begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  // ----------------------------------------
  // completion flags
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      foreground_complete_flag     <= 1'b0;
      cal_stopped <= 1'b0;
    end else if (ce_i) begin
      if (!run) begin
        foreground_complete_flag     <= 1'b0;
        cal_stopped <= 1'b0;
      end else begin
        if (ev_fg) begin
          foreground_complete_flag <= 1'b1;
        end
        if (ev_stop) begin
          cal_stopped <= 1'b1;
        end else if (next_state == ST_BG_RUN) begin
          cal_stopped <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // interrupt
  // ----------------------------------------
  // sticky events, write one clears, set wins
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      int_stat <= 2'h0;
    end else if (ce_i) begin
      for (int b = 0; b < 2; b++) begin
        if ((b == `BIT_EV_FG) ? ev_fg : ev_stop) begin
          int_stat[b] <= 1'b1;
        end else if (ph_we && hit(ph_idx, `IDX_INT_STAT) && hwdata_i[b]) begin
          int_stat[b] <= 1'b0;
        end
      end
    end
  end

  // level output from flops
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= |(int_stat & int_mask);
    end
  end

  // ----------------------------------------
  // datapath controls
  // ----------------------------------------
  // registered so every output is glitch free
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cal_reset_o                 <= 1'b1;
      divider_reset_o             <= 1'b1;
      cal_values_clear_o          <= 1'b0;
      fg_running_o                <= 1'b0;
      fg_offset_running_o         <= 1'b0;
      bg_running_o                <= 1'b0;
      bg_offset_running_o         <= 1'b0;
      offset_averaging_depth_o    <= 3'h0;
      linearity_averaging_depth_o <= 3'h0;
    end else if (ce_i) begin
      cal_reset_o                 <= !run;
      divider_reset_o             <= !run;
      cal_values_clear_o          <= (next_state == ST_CLEAR);
      fg_running_o                <= (next_state == ST_FG_LIN);
      fg_offset_running_o         <= (next_state == ST_FG_OS);
      bg_running_o                <= (next_state == ST_BG_RUN);
      bg_offset_running_o         <= (next_state == ST_BG_RUN) &&
                                     cfg_a[`BIT_BG_OS];
      offset_averaging_depth_o    <= offset_averaging_depth;
      linearity_averaging_depth_o <= lin_avg;
    end
  end

  // excluded core, only while background is off
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      core_disable_o <= 3'h0;
      core_standin_o <= 1'b0;
    end else if (ce_i) begin
      core_disable_o <= 3'h0;
      core_standin_o <= 1'b0;
      if (!cfg_a[`BIT_BG]) begin
        if (core_sel == `CORE_CODE_0) begin
          core_disable_o <= 3'h1;
          core_standin_o <= 1'b1;
        end else if (core_sel == `CORE_CODE_1) begin
          core_disable_o <= 3'h2;
        end else if (core_sel == `CORE_CODE_2) begin
          core_disable_o <= 3'h4;
          core_standin_o <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // unused inputs
  // ----------------------------------------
  // link enable and size are observed by software
  // ordering only; the logic does not need them
  logic unused_ok;
  assign unused_ok = link_output_enable_i ^ (^hsize_i) ^ htrans_i[0];

endmodule

/* tb/converter_calibration_control_props.sv */
`timescale 1ns/100ps
// --------------------------------
// sequencer and core select checks
// --------------------------------
module converter_calibration_control_props (
  input wire logic       clk_i,
  input wire logic       arst_n_i,
  input wire logic       ce_i,
  input wire logic       cal_reset_o,
  input wire logic       divider_reset_o,
  input wire logic       cal_values_clear_o,
  input wire logic       fg_running_o,
  input wire logic       fg_offset_running_o,
  input wire logic       bg_running_o,
  input wire logic       bg_offset_running_o,
  input wire logic [2:0] core_disable_o,
  input wire logic       core_standin_o
);
  // one clock domain, one reset
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);

  property p_div_rst;
    divider_reset_o == cal_reset_o;
  endproperty
  a_div_rst: assert property (p_div_rst)
    else $error("divider reset differs from cal reset");

  // one cycle of slack while the hold settles
  property p_hold_idle;
    cal_reset_o && $past(cal_reset_o) |->
      !(fg_running_o || fg_offset_running_o || bg_running_o || bg_offset_running_o);
  endproperty
  a_hold_idle: assert property (p_hold_idle)
    else $error("calibration phase active while held");

  property p_clear_pulse;
    cal_values_clear_o && ce_i |=> !cal_values_clear_o;
  endproperty
  a_clear_pulse: assert property (p_clear_pulse)
    else $error("value clear longer than one cycle");

  property p_clear_on_start;
    $fell(cal_reset_o) |-> ##[0:2] cal_values_clear_o;
  endproperty
  a_clear_on_start: assert property (p_clear_on_start)
    else $error("no value clear after leaving hold");

  property p_os_after_lin;
    $rose(fg_offset_running_o) |-> $past(fg_running_o);
  endproperty
  a_os_after_lin: assert property (p_os_after_lin)
    else $error("offset phase not preceded by linearity");

  property p_phase_excl;
    $onehot0({fg_running_o, fg_offset_running_o, bg_running_o, cal_values_clear_o});
  endproperty
  a_phase_excl: assert property (p_phase_excl)
    else $error("two calibration phases at once");

  property p_bgos_no_fg;
    bg_offset_running_o |-> !(fg_running_o || fg_offset_running_o);
  endproperty
  a_bgos_no_fg: assert property (p_bgos_no_fg)
    else $error("background offset during foreground");

  property p_core_onehot;
    $onehot0(core_disable_o);
  endproperty
  a_core_onehot: assert property (p_core_onehot)
    else $error("more than one core disabled");

  property p_standin;
    core_standin_o |-> (core_disable_o[0] || core_disable_o[2]);
  endproperty
  a_standin: assert property (p_standin)
    else $error("stand-in without core 0 or 2 off");

  property p_core_bg;
    bg_running_o |-> core_disable_o == 3'h0;
  endproperty
  a_core_bg: assert property (p_core_bg)
    else $error("core disabled during background run");
endmodule

bind converter_calibration_control converter_calibration_control_props
  converter_calibration_control_props_i (.clk_i, .arst_n_i, .ce_i, .cal_reset_o,
  .divider_reset_o, .cal_values_clear_o, .fg_running_o, .fg_offset_running_o,
  .bg_running_o, .bg_offset_running_o, .core_disable_o, .core_standin_o);

/* tb/converter_calibration_control_tb.sv */
`timescale 1ns/100ps
`include "calib_cfg.svh"
module converter_calibration_control_tb;
  import calib_pkg::*;
  localparam int BC = 2;  // short unit keeps phases brief
  logic        clk_i    = 0;
  logic        arst_n_i = 0;
  logic        hsel_i   = 0;
  logic [11:0] haddr_i  = 0;
  logic [1:0]  htrans_i = 0;
  logic        hwrite_i = 0;
  logic [31:0] hwdata_i = 0;
  logic        link_output_enable_i = 0;
  logic [31:0] hrdata_o;
  logic        hreadyout_o, hresp_o, cal_reset_o, divider_reset_o, cal_values_clear_o;
  logic        fg_running_o, fg_offset_running_o, bg_running_o, bg_offset_running_o;
  logic [2:0]  offset_averaging_depth_o, linearity_averaging_depth_o, core_disable_o;
  logic        core_standin_o, irq_o;
  int          mismatches = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          cnt_fg, cnt_os, cnt_clr, saw_bgos;  // phase monitors

  always #4 clk_i = ~clk_i;

  converter_calibration_control #(.ADDR_W(12), .BASE_CYC(BC)) converter_calibration_control_i (
    .clk_i, .arst_n_i, .ce_i(1'b1), .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
    .hsize_i(3'h2), .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o,
    .hresp_o, .link_output_enable_i, .cal_reset_o, .divider_reset_o,
    .cal_values_clear_o, .fg_running_o, .fg_offset_running_o, .bg_running_o,
    .bg_offset_running_o, .offset_averaging_depth_o, .linearity_averaging_depth_o,
    .core_disable_o, .core_standin_o, .irq_o);

  // --------------------------------
  // monitors and hang guard
  // --------------------------------
  // phase lengths counted per cycle; cleared only while held
  always @(posedge clk_i) begin
    if (fg_running_o === 1'b1) cnt_fg <= cnt_fg + 1;
    if (fg_offset_running_o === 1'b1) cnt_os <= cnt_os + 1;
    if (cal_values_clear_o === 1'b1) cnt_clr <= cnt_clr + 1;
    if (bg_offset_running_o === 1'b1) saw_bgos <= 1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      print_verdict;
    end
  end

  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // --------------------------------
  // bus master, zero-wait aware
  // --------------------------------
  // address phase held until hready, then data phase
  task automatic bus(input logic [7:0] idx, input logic wr, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk_i);
    hsel_i   <= 1'b1;
    haddr_i  <= {2'h0, idx, 2'h0};
    htrans_i <= 2'h2;
    hwrite_i <= wr;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] x;
    bus(idx, 1'b1, {24'h0, d}, x);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp, input string what);
    logic [31:0] x;
    bus(idx, 1'b0, 32'h0, x);
    chk(x, {24'h0, exp}, what);
  endtask

  // polls status until it matches, bounded
  task automatic wait_stat(input logic [7:0] exp, input string what);
    logic [31:0] x;
    int n;
    n = 0;
    do begin
      bus(`IDX_STATUS, 1'b0, 32'h0, x);
      n++;
    end while (x !== {24'h0, exp} && n < 300);
    chk(x, {24'h0, exp}, what);
  endtask

  // hold, load settings, run again; link kept off meanwhile
  task automatic rerun(input logic [7:0] cfg, input logic [7:0] avg);
    link_output_enable_i <= 1'b0;
    wr(`IDX_CTRL, 8'h00);
    rdc(`IDX_STATUS, 8'h00, "held status");
    chk(cal_reset_o & divider_reset_o, 1, "dividers held");
    wr(`IDX_CFG_A, cfg);
    wr(`IDX_AVG, avg);
    cnt_fg  = 0;
    cnt_os  = 0;
    cnt_clr = 0;
    saw_bgos = 0;
    wr(`IDX_CTRL, 8'h01);
    link_output_enable_i <= 1'b1;
  endtask

  // --------------------------------
  // scenarios
  // --------------------------------
  task automatic t_regs;
    rdc(`IDX_CTRL, 8'h01, "ctrl reset");
    rdc(`IDX_CFG_A, 8'h01, "cfg a reset");
    rdc(`IDX_CFG_B, 8'h02, "cfg b reset");
    rdc(`IDX_AVG, 8'h61, "avg reset");
    rdc(8'h69, 8'h00, "unmapped read");
    chk({hreadyout_o, hresp_o}, 2'b10, "bus ready okay");
    chk(offset_averaging_depth_o, 6, "os depth out");
    chk(linearity_averaging_depth_o, 1, "lin depth out");
  endtask

  // foreground with offset: exact phase lengths from depth fields
  task automatic t_fg;
    rerun(8'h05, 8'h12);
    wait_stat({3'h0, CODE_DONE, 2'h3}, "foreground_complete_flag status");
    chk(cnt_fg, (BC << 2) + 1, "lin phase length");
    chk(cnt_os, (BC << 1) + 1, "os phase length");
    chk(cnt_clr, 1, "values cleared");
    chk(offset_averaging_depth_o, 1, "os depth out");
    chk(linearity_averaging_depth_o, 2, "lin depth out");
    chk(irq_o, 0, "masked irq");
    rdc(`IDX_INT_STAT, 8'h03, "events");
    wr(`IDX_INT_STAT, 8'h03);
    rdc(`IDX_INT_STAT, 8'h00, "events cleared");
  endtask

  // foreground skipped; offset bit alone must not run
  task automatic t_skip;
    rerun(8'h04, 8'h12);
    wait_stat({3'h0, CODE_DONE, 2'h3}, "skip status");
    chk(cnt_fg + cnt_os, 0, "no fg phases");
    chk(cnt_clr, 1, "values cleared");
    wr(`IDX_STATUS, 8'hff);
    rdc(`IDX_STATUS, {3'h0, CODE_DONE, 2'h3}, "status read only");
  endtask

  // background run, stop at phase end, resume
  task automatic t_bg;
    wr(`IDX_INT_MASK, 8'h02);
    rerun(8'h0b, 8'h00);
    wait_stat({3'h0, CODE_BG_RUN, 2'h1}, "bg running");
    chk(core_disable_o, 0, "no core off in bg");
    wr(`IDX_INT_STAT, 8'h03);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 0, "irq cleared");
    wr(`IDX_BG_CTRL, 8'h01);
    wait_stat({3'h0, CODE_BG_STOP, 2'h3}, "bg stopped");
    chk(bg_running_o, 0, "bg halted");
    chk(saw_bgos, 1, "bg offset ran");
    repeat (2) @(posedge clk_i);
    chk(irq_o, 1, "stop irq");
    wr(`IDX_INT_MASK, 8'h00);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 0, "irq masked");
    wr(`IDX_INT_MASK, 8'h02);
    wr(`IDX_INT_STAT, 8'h02);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 0, "irq w1c");
    rdc(`IDX_INT_STAT, 8'h00, "stat w1c");
    wr(`IDX_BG_CTRL, 8'h00);
    wait_stat({3'h0, CODE_BG_RUN, 2'h1}, "bg resumed");
  endtask

  // every excluded core code, link off while the codes are stepped
  task automatic t_core;
    logic [2:0] dis [4] = '{3'h1, 3'h2, 3'h4, 3'h0};
    logic       sti [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    rerun(8'h01, 8'h00);
    @(posedge clk_i);
    link_output_enable_i <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      wr(`IDX_CFG_B, 8'(c));
      repeat (2) @(posedge clk_i);
      chk(core_disable_o, dis[c], "core off");
      chk(core_standin_o, sti[c], "core stand-in");
      rdc(`IDX_CFG_B, 8'(c), "cfg b readback");
    end
  endtask

  initial begin
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1'b1;
    t_regs;
    t_fg;
    t_skip;
    t_bg;
    t_core;
    print_verdict;
  end
endmodule
